// File: common/pcr_regs.svh
// constants of the power-up configuration restore block
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH
`define PCR_CLK_MHZ       100
// nonvolatile image layout, byte addresses
`define PCR_NV_SHORT      6'h00
`define PCR_NV_ALO        6'h01
`define PCR_NV_AHI        6'h03
`define PCR_NV_OFS        6'h05
`define PCR_NV_IO         6'h07
`define PCR_NV_CFG1       6'h08
`define PCR_NV_CFG2       6'h09
`define PCR_NV_PROT       6'h0a
`define PCR_NV_KEY        6'h0b
`define PCR_NV_LAST       6'h2a
`define PCR_NV_WORDS      43
`define PCR_KEY_BYTES     32
// device configuration-1 fields
`define PCR_ARB_HI        1
`define PCR_ARB_LO        0
`define PCR_FSE_BIT       2
`define PCR_ARB_MIN       2'h2
// operation durations, maximum figures
`define PCR_T_HASH_US     380
`define PCR_T_DECOM_MS    130
`define PCR_T_PROG_MS     21
`define PCR_T_COPY_MS     42
`define PCR_T_RDIDLE_US   560
`define PCR_US_CYC(t)     ((t) * `PCR_CLK_MHZ)
`define PCR_MS_CYC(t)     ((t) * 1000 * `PCR_CLK_MHZ)
`define PCR_CNT_W         24
`endif

// File: common/pcr_pkg.sv
// types of the power-up configuration restore block
`default_nettype none
package pcr_pkg;
    typedef enum logic [1:0] {
        PCR_OP_HASH,
        PCR_OP_DECOM,
        PCR_OP_PROG,
        PCR_OP_COPY
    } pcr_op_t;

    typedef struct packed {
        logic [7:0]  short_addr;
        logic [15:0] alert_lo;
        logic [15:0] alert_hi;
        logic [15:0] offset;
        logic [7:0]  io_cfg;
        logic [7:0]  cfg1;
        logic [7:0]  cfg2;
        logic [7:0]  protect;
    } pcr_cfg_t;

    typedef struct packed {
        logic       req;
        logic [5:0] addr;
    } pcr_nv_req_t;
endpackage
`default_nettype wire

// File: hw/pcr_top.sv
// power-up restore, bus-reset gating, power-mode and operation timing
//
// Overview of operation
// R1: ignore and never answer data line activity while restore runs
// R2: after restore, stay idle until host bus reset, then talk
// R3: reload short address, alert thresholds and offset from nonvolatile memory
// R4: reload IO configuration register from stored setup word
// R5: reload both device configuration registers from nonvolatile memory
// R6: arbitration_select of 10b or 11b selects arbitration search answers
// R7: fast_speed_enable gives overdrive unless first bus reset was standard speed
// R8: reload protection bits and enforce them on user EEPROM pages
// R9: load key and secret bytes into internal flip-flops
// R10: supply loss with enough stored charge keeps every setting unchanged
// R11: brown-out shuts down; next power-up runs bus-powered
// R12: after any power-up, a bus reset starts first valid communication
// R13: hash over 8 bytes completes within 380 us
// R14: decommission completes within 130 ms
// R15: 8-byte EEPROM word program completes within 21 ms
// R16: register copy to EEPROM completes within 42 ms
// R17: host allows up to 560 us idle per 8-byte EEPROM read
// R18: host keeps line idle high during conversion and EEPROM access
// R19: host keeps reset low under 600 us in bus-powered mode
// R20: all restore steps finish before first bus reset is acknowledged
`timescale 1ns/1ns
`default_nettype none
`include "pcr_regs.svh"

module pcr_top #(
    parameter int unsigned HASH_CYC  = `PCR_US_CYC(`PCR_T_HASH_US),
    parameter int unsigned DECOM_CYC = `PCR_MS_CYC(`PCR_T_DECOM_MS),
    parameter int unsigned PROG_CYC  = `PCR_MS_CYC(`PCR_T_PROG_MS),
    parameter int unsigned COPY_CYC  = `PCR_MS_CYC(`PCR_T_COPY_MS)
) (
    input  wire logic                clock_i,        // 100 MHz clock
    input  wire logic                rst_i,          // power-on reset, sync
    output pcr_pkg::pcr_nv_req_t     nv_req_o,       // nonvolatile read request
    input  wire logic                nv_valid_i,     // read data valid
    input  wire logic [7:0]          nv_data_i,      // read data byte
    input  wire logic                bus_reset_i,    // host bus reset seen
    input  wire logic                bus_reset_od_i, // that reset was overdrive
    output logic                     presence_o,     // acknowledge bus reset
    output logic                     bus_active_o,   // communication allowed
    output logic                     bus_listen_o,   // line decoder enabled
    output logic                     overdrive_o,    // overdrive speed in use
    output logic                     arb_search_o,   // arbitration search mode
    output pcr_pkg::pcr_cfg_t        cfg_o,          // restored working regs
    output logic [7:0]               page_wp_o,      // per-page write block
    input  wire logic [4:0]          key_idx_i,      // secret byte select
    output logic [7:0]               key_byte_o,     // selected secret byte
    input  wire logic                vdd_good_i,     // supply pin present
    input  wire logic                charge_ok_i,    // storage above brown-out
    output logic                     bus_powered_o,  // bus-powered mode
    output logic                     powered_o,      // device not shut down
    input  wire logic                op_start_i,     // start timed operation
    input  wire pcr_pkg::pcr_op_t    op_kind_i,      // operation kind
    output logic                     op_busy_o,      // operation running
    output logic                     op_done_o       // operation finished
);
    import pcr_pkg::*;

    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PCR_ST_FETCH,
        PCR_ST_WAITD,
        PCR_ST_IDLE,
        PCR_ST_LIVE,
        PCR_ST_OFF
    } pcr_state_t;

    pcr_state_t st_ff;
    pcr_state_t nxt_st;
    logic [5:0] idx_ff;
    logic [5:0] nxt_idx;
    logic [7:0] img_ff [`PCR_NV_WORDS];
    logic       pres_ff;
    logic       od_ff;
    logic       first_od_ff;
    logic       bpow_ff;
    logic       busy_ff;
    logic       done_ff;
    pcr_op_t    kind_ff;
    logic [`PCR_CNT_W-1:0] cnt_ff;
    logic [`PCR_CNT_W-1:0] lim_ff;
    logic [7:0] key_ff;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire restoring  = (st_ff == PCR_ST_FETCH) || (st_ff == PCR_ST_WAITD);
    wire listen_w   = (st_ff == PCR_ST_IDLE) || (st_ff == PCR_ST_LIVE);
    wire last_w     = (idx_ff == `PCR_NV_LAST);
    wire byte_in    = (st_ff == PCR_ST_WAITD) && nv_valid_i;
    wire brownout   = !charge_ok_i && (st_ff != PCR_ST_OFF);
    wire accept_rst = listen_w && bus_reset_i;
    wire op_go      = op_start_i && !busy_ff && (st_ff == PCR_ST_LIVE);
    wire [`PCR_CNT_W-1:0] op_lim;
    assign op_lim = (op_kind_i == PCR_OP_HASH)  ? `PCR_CNT_W'(HASH_CYC)  :
                    (op_kind_i == PCR_OP_DECOM) ? `PCR_CNT_W'(DECOM_CYC) :
                    (op_kind_i == PCR_OP_PROG)  ? `PCR_CNT_W'(PROG_CYC)  :
                                                  `PCR_CNT_W'(COPY_CYC);

    always_comb begin
        nxt_st  = st_ff;
        nxt_idx = idx_ff;
        case (st_ff)
            PCR_ST_FETCH: nxt_st = PCR_ST_WAITD;
            PCR_ST_WAITD: begin
                if (nv_valid_i) begin
                    nxt_st  = last_w ? PCR_ST_IDLE : PCR_ST_FETCH; // R20
                    nxt_idx = idx_ff + 6'h01;
                end
            end
            PCR_ST_IDLE: begin
                if (bus_reset_i) begin
                    nxt_st = PCR_ST_LIVE; // R2 R12
                end
            end
            PCR_ST_LIVE: nxt_st = PCR_ST_LIVE;
            PCR_ST_OFF: begin
                if (charge_ok_i) begin
                    nxt_st  = PCR_ST_FETCH;
                    nxt_idx = 6'h00;
                end
            end
            default: nxt_st = PCR_ST_OFF;
        endcase
        if (brownout) begin
            nxt_st = PCR_ST_OFF; // R11
        end
    end

    // ------------------------------------------------------------
    // restore sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_ff  <= PCR_ST_FETCH;
            idx_ff <= 6'h00;
        end else begin
            st_ff  <= nxt_st;
            idx_ff <= nxt_idx;
        end
    end

    // one byte per entry; the whole image lands before the bus opens
    genvar gi;
    generate
        for (gi = 0; gi < `PCR_NV_WORDS; gi++) begin : g_img
            always_ff @(posedge clock_i) begin
                if (rst_i) begin
                    img_ff[gi] <= 8'h00;
                end else if (byte_in && idx_ff == 6'(gi)) begin
                    img_ff[gi] <= nv_data_i; // R3 R4 R5 R8 R9
                end
            end
        end
        for (gi = 0; gi < 8; gi++) begin : g_wp
            // protection only bites once the restored byte is in place
            assign page_wp_o[gi] = cfg_o.protect[gi] && !restoring; // R8
        end
    endgenerate

    assign nv_req_o.req  = (st_ff == PCR_ST_FETCH);
    assign nv_req_o.addr = idx_ff;

    // ------------------------------------------------------------
    // working registers seen by the rest of the device
    // ------------------------------------------------------------
    assign cfg_o.short_addr = img_ff[`PCR_NV_SHORT]; // R3
    assign cfg_o.alert_lo   = {img_ff[`PCR_NV_ALO+1], img_ff[`PCR_NV_ALO]};
    assign cfg_o.alert_hi   = {img_ff[`PCR_NV_AHI+1], img_ff[`PCR_NV_AHI]};
    assign cfg_o.offset     = {img_ff[`PCR_NV_OFS+1], img_ff[`PCR_NV_OFS]};
    assign cfg_o.io_cfg     = img_ff[`PCR_NV_IO]; // R4
    assign cfg_o.cfg1       = img_ff[`PCR_NV_CFG1]; // R5
    assign cfg_o.cfg2       = img_ff[`PCR_NV_CFG2]; // R5
    assign cfg_o.protect    = img_ff[`PCR_NV_PROT];

    wire [1:0] arb_sel = cfg_o.cfg1[`PCR_ARB_HI:`PCR_ARB_LO];
    wire       fse     = cfg_o.cfg1[`PCR_FSE_BIT];
    assign arb_search_o = (arb_sel >= `PCR_ARB_MIN); // R6

    // ------------------------------------------------------------
    // bus reset handling and speed
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pres_ff     <= 1'b0;
            first_od_ff <= 1'b0;
            od_ff       <= 1'b0;
        end else begin
            pres_ff <= accept_rst; // R1 R12
            if (st_ff == PCR_ST_IDLE && bus_reset_i) begin
                first_od_ff <= bus_reset_od_i;
                od_ff       <= fse && bus_reset_od_i; // R7
            end else if (!listen_w) begin
                od_ff <= 1'b0;
            end
        end
    end

    assign presence_o   = pres_ff;
    assign bus_active_o = (st_ff == PCR_ST_LIVE);
    assign bus_listen_o = listen_w; // R1
    assign overdrive_o  = od_ff;

    // ------------------------------------------------------------
    // power mode; supply loss alone touches nothing else
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bpow_ff <= 1'b0;
        end else if (st_ff == PCR_ST_OFF) begin
            bpow_ff <= 1'b1; // R11
        end else if (restoring) begin
            bpow_ff <= bpow_ff || !vdd_good_i;
        end else if (!vdd_good_i) begin
            bpow_ff <= 1'b1; // R10
        end
    end

    assign bus_powered_o = bpow_ff;
    assign powered_o     = (st_ff != PCR_ST_OFF);

    // ------------------------------------------------------------
    // secret byte read port
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            key_ff <= 8'h00;
        end else begin
            key_ff <= img_ff[`PCR_NV_KEY + 6'(key_idx_i)]; // R9
        end
    end

    assign key_byte_o = key_ff;

    // ------------------------------------------------------------
    // operation timer; runs to the maximum figure of each kind
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            cnt_ff  <= '0;
            lim_ff  <= '0;
            kind_ff <= PCR_OP_HASH;
        end else begin
            done_ff <= 1'b0;
            if (brownout) begin
                busy_ff <= 1'b0;
            end else if (op_go) begin
                busy_ff <= 1'b1;
                cnt_ff  <= `PCR_CNT_W'(1);
                lim_ff  <= op_lim;
                kind_ff <= op_kind_i;
            end else if (busy_ff && cnt_ff >= lim_ff) begin
                busy_ff <= 1'b0; // R13 R14 R15 R16
                done_ff <= 1'b1;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff + `PCR_CNT_W'(1);
            end
        end
    end

    assign op_busy_o = busy_ff;
    assign op_done_o = done_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    quiet_init_a: assert property (presence_o |-> $past(listen_w) && $past(bus_reset_i)) // R1
        else $error("presence answered while not listening");
    idle_wait_a: assert property ((st_ff == PCR_ST_IDLE) && !bus_reset_i && charge_ok_i // R2
                                  |=> (st_ff == PCR_ST_IDLE))
        else $error("left idle without bus reset");
    first_rst_a: assert property ((st_ff == PCR_ST_IDLE) && bus_reset_i && charge_ok_i // R12
                                  |=> bus_active_o && presence_o)
        else $error("first bus reset not taken");
    restore_end_a: assert property ($rose(bus_listen_o) |-> $past(last_w) && $past(nv_valid_i)) // R20
        else $error("bus opened before image complete");
    byte_load_a: assert property (byte_in && (idx_ff == `PCR_NV_CFG1) && !brownout // R5
                                  |=> cfg_o.cfg1 == $past(nv_data_i))
        else $error("configuration byte not restored");
    arbitration_select_a: assert property (bus_active_o |-> arb_search_o == arb_sel[1]) // R6
        else $error("arbitration mode mismatch");
    speed_sel_a: assert property (overdrive_o |-> fse && first_od_ff) // R7
        else $error("overdrive without enable or after standard reset");
    wp_apply_a: assert property (bus_active_o |-> page_wp_o == cfg_o.protect) // R8
        else $error("page protection not enforced");
    supply_hold_a: assert property (bus_active_o && $fell(vdd_good_i) && charge_ok_i // R10
                                    |-> $stable(cfg_o) && $stable(overdrive_o))
        else $error("settings changed on supply loss");
    brownout_a: assert property (!charge_ok_i && powered_o |=> !powered_o ##1 bus_powered_o) // R11
        else $error("no shutdown on brown-out");
    hash_time_a: assert property (busy_ff && kind_ff == PCR_OP_HASH // R13
                                  |-> cnt_ff <= `PCR_CNT_W'(HASH_CYC))
        else $error("hash overran its time");
    decom_time_a: assert property (busy_ff && kind_ff == PCR_OP_DECOM // R14
                                   |-> cnt_ff <= `PCR_CNT_W'(DECOM_CYC))
        else $error("decommission overran its time");
    prog_time_a: assert property (busy_ff && kind_ff == PCR_OP_PROG // R15
                                  |-> cnt_ff <= `PCR_CNT_W'(PROG_CYC))
        else $error("word program overran its time");
    copy_time_a: assert property (busy_ff && kind_ff == PCR_OP_COPY // R16
                                  |-> cnt_ff <= `PCR_CNT_W'(COPY_CYC))
        else $error("register copy overran its time");

    restore_c: cover property ($rose(bus_listen_o));
    od_live_c: cover property (bus_active_o && overdrive_o);
    brown_c:   cover property (powered_o ##1 !powered_o ##[1:600] bus_listen_o);
    op_done_c: cover property (op_done_o && kind_ff == PCR_OP_HASH);
endmodule
`default_nettype wire

// File: tb/pcr_nv_model.sv
// nonvolatile store model answering the restore byte requests
`timescale 1ns/1ns
`default_nettype none
`include "pcr_regs.svh"

module pcr_nv_model (
    input  wire logic                 clock_i,    // bench clock
    input  wire logic                 rst_i,      // sync reset, active high
    input  wire pcr_pkg::pcr_nv_req_t nv_req_i,   // byte request from restore
    input  wire logic                 slow_i,     // stretch answer latency
    input  wire logic [7:0]           cfg1_i,     // stored config-1 byte
    output logic                      nv_valid_o, // read byte valid
    output logic [7:0]                nv_data_o   // read byte
);
    import pcr_pkg::*;

    logic       pend_ff;
    logic [2:0] wait_ff;
    logic [5:0] addr_ff;
    logic [7:0] data_ff;

    // ------------------------------------------------------------
    // image: a0 plus address, except the config-1 byte
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pend_ff    <= 1'b0;
            wait_ff    <= 3'h0;
            nv_valid_o <= 1'b0;
        end else begin
            nv_valid_o <= 1'b0;
            if (nv_req_i.req && !pend_ff) begin
                pend_ff <= 1'b1;
                wait_ff <= slow_i ? 3'h3 : 3'h0;
                addr_ff <= nv_req_i.addr;
            end else if (pend_ff && wait_ff == 3'h0) begin
                pend_ff    <= 1'b0;
                nv_valid_o <= 1'b1;
                data_ff    <= (addr_ff == `PCR_NV_CFG1) ? cfg1_i : 8'ha0 + {2'h0, addr_ff};
            end else if (pend_ff) begin
                wait_ff <= wait_ff - 3'h1;
            end
        end
    end

    // outside the valid cycle the byte lanes carry garbage, not the last byte
    assign nv_data_o = nv_valid_o ? data_ff : ~data_ff;
endmodule
`default_nettype wire

// File: tb/powerup_config_restore_test.sv
// self-checking bench for the power-up configuration restore block
`timescale 1ns/1ns
`default_nettype none
`include "pcr_regs.svh"

module powerup_config_restore_test;
    import pcr_pkg::*;

    localparam int unsigned OP_L [4] = '{20, 40, 30, 50};

    logic        clock_i, rst_i, nv_valid, bus_reset, bus_reset_od, presence;
    logic        bus_active, bus_listen, overdrive, arb_search, vdd_good, charge_ok;
    logic        bus_powered, powered, op_start, op_busy, op_done, slow;
    logic [7:0]  nv_data, page_wp, key_byte, cfg1_img;
    logic [4:0]  key_idx;
    pcr_nv_req_t nv_req;
    pcr_cfg_t    cfg, exp_cfg;
    pcr_op_t     op_kind;
    int          err_count, checked;

    pcr_top #(.HASH_CYC(20), .DECOM_CYC(40), .PROG_CYC(30), .COPY_CYC(50)) u_pcr_top (
        .clock_i(clock_i), .rst_i(rst_i), .nv_req_o(nv_req), .nv_valid_i(nv_valid),
        .nv_data_i(nv_data), .bus_reset_i(bus_reset), .bus_reset_od_i(bus_reset_od),
        .presence_o(presence), .bus_active_o(bus_active), .bus_listen_o(bus_listen),
        .overdrive_o(overdrive), .arb_search_o(arb_search), .cfg_o(cfg),
        .page_wp_o(page_wp), .key_idx_i(key_idx), .key_byte_o(key_byte),
        .vdd_good_i(vdd_good), .charge_ok_i(charge_ok), .bus_powered_o(bus_powered),
        .powered_o(powered), .op_start_i(op_start), .op_kind_i(op_kind),
        .op_busy_o(op_busy), .op_done_o(op_done));

    pcr_nv_model u_pcr_nv_model (
        .clock_i(clock_i), .rst_i(rst_i), .nv_req_i(nv_req), .slow_i(slow),
        .cfg1_i(cfg1_img), .nv_valid_o(nv_valid), .nv_data_o(nv_data));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %0b seen %0b", what, exp, got);
        end
    endtask

    task automatic chk_vec(input string what, input logic [95:0] exp, input logic [95:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [7:0] img(input int a);
        return (a == `PCR_NV_CFG1) ? cfg1_img : 8'ha0 + 8'(a);
    endfunction

    // ------------------------------------------------------------
    // host and restore sequences
    // ------------------------------------------------------------
    task automatic host_reset(input logic od, input logic exp_pres);
        bus_reset    = 1'b1;
        bus_reset_od = od;
        @(negedge clock_i);
        bus_reset = 1'b0;
        chk_bit("presence", exp_pres, presence);
        @(negedge clock_i);
        chk_bit("presence width", 1'b0, presence);
    endtask

    task automatic wait_restore();
        int n;
        n = 0;
        chk_vec("page_wp restoring", 96'h0, 96'(page_wp));
        while (!bus_listen && n < 2000) begin
            @(negedge clock_i);
            n++;
        end
        chk_bit("restore done", 1'b1, bus_listen);
    endtask

    task automatic check_restore();
        exp_cfg = '{short_addr: img(0), alert_lo: {img(2), img(1)}, alert_hi: {img(4), img(3)},
                    offset: {img(6), img(5)}, io_cfg: img(7), cfg1: img(8), cfg2: img(9),
                    protect: img(10)};
        chk_vec("cfg", 96'(exp_cfg), 96'(cfg));
        chk_vec("page_wp", 96'(img(10)), 96'(page_wp));
        chk_bit("arb_search", cfg1_img[1], arb_search);
        chk_bit("bus_active", 1'b0, bus_active);
        for (int k = 0; k < 32; k++) begin
            key_idx = 5'(k);
            @(negedge clock_i);
            chk_vec("key byte", 96'(img(11 + k)), 96'(key_byte));
        end
        op_start = 1'b1;
        @(negedge clock_i);
        op_start = 1'b0;
        @(negedge clock_i);
        chk_bit("op before reset", 1'b0, op_busy);
    endtask

    // the host keeps the line quiet while an operation runs
    task automatic run_op(input pcr_op_t kind, input int lim);
        int n;
        op_kind  = kind;
        op_start = 1'b1;
        @(negedge clock_i);
        op_start = 1'b0;
        n = 1;
        chk_bit("op busy", 1'b1, op_busy);
        while (!op_done && n < 200) begin
            @(negedge clock_i);
            n++;
            op_start = (n == 3);
        end
        op_start = 1'b0;
        chk_vec("op cycles", 96'(lim + 1), 96'(n));
        chk_bit("op busy drop", 1'b0, op_busy);
    endtask

    initial begin
        rst_i = 1'b1;   bus_reset = 1'b0;  bus_reset_od = 1'b0; vdd_good = 1'b1;
        charge_ok = 1'b1; op_start = 1'b0; op_kind = PCR_OP_HASH; key_idx = 5'h0;
        slow = 1'b0;    cfg1_img = 8'h07;  err_count = 0;       checked = 0;
        repeat (3) @(negedge clock_i);
        rst_i = 1'b0;
        host_reset(1'b1, 1'b0);
        wait_restore();
        check_restore();
        host_reset(1'b0, 1'b1);
        chk_bit("standard first reset", 1'b0, overdrive);
        chk_bit("bus_active", 1'b1, bus_active);
        for (int i = 0; i < 4; i++)
            run_op(pcr_op_t'(i), OP_L[i]);
        host_reset(1'b1, 1'b1);
        chk_bit("speed fixed", 1'b0, overdrive);
        vdd_good = 1'b0;
        repeat (3) @(negedge clock_i);
        chk_bit("supply loss mode", 1'b1, bus_powered);
        chk_vec("supply loss cfg", 96'(exp_cfg), 96'(cfg));
        chk_bit("supply loss active", 1'b1, bus_active);
        for (int i = 0; i < 2; i++) begin
            charge_ok = 1'b0;
            @(negedge clock_i);
            chk_bit("brown-out off", 1'b0, powered);
            @(negedge clock_i);
            chk_bit("brown-out mode", 1'b1, bus_powered);
            cfg1_img  = (i == 0) ? 8'h02 : 8'h05;
            slow      = 1'b1;
            charge_ok = 1'b1;
            @(negedge clock_i);
            wait_restore();
            check_restore();
            host_reset(1'b1, 1'b1);
            chk_bit("overdrive", cfg1_img[2], overdrive);
            chk_bit("powered again", 1'b1, powered);
        end
        wrap_up();
    end

    // whole run is under a thousand cycles; this bound is far above it
    initial begin
        #300000;
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
